// File: dv/tb_telemetry_calibration_sequencer.sv
// Self-checking bench for the calibration sequencer
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, s) begin n_compared++; if ((s) !== (e)) begin \
  bad_count++; $display("[ERR] %s exp %0h got %0h", nm, e, s); end end
module tb_telemetry_calibration_sequencer;
  import tcs_pkg::*;
  localparam int SC = 4;
  localparam int FR = 3;
  logic i_clk = 0, i_reset = 1, fire = 0, gse = 0, pre = 0, ctl = 0;
  logic ce = 1;
  logic mux_cal;
  logic [2:0] mux_level;
  logic [2:0] sel = 3'h0;
  logic start, on_bus, busy, done;
  level_t level;
  logic [5:0] mux;
  logic [2:0] sb;
  int bad_count = 0, n_compared = 0;
  ////////////////////////////////////////////////////////////////////////
  telemetry_calibration_sequencer #(.STEP_CYCLES(SC))
    telemetry_calibration_sequencer_i (
    .i_clk(i_clk), .i_reset(i_reset), .i_ce(ce),
    .i_start_flight_computer(start),
    .i_start_ground_support_equipment(gse), .i_prelaunch(pre),
    .i_ground_level_ctl(ctl), .i_ground_level_sel(sel), .o_level(level),
    .o_mux_en(mux), .o_sideband_en(sb), .o_busy(busy), .o_pass_done(done));
  tcs_partner #(.FRAME(FR)) tcs_partner_i (.i_clk(i_clk), .i_fire(fire),
    .i_en(mux[0]), .i_mux_en(mux[1]), .o_start(start), .o_on_bus(on_bus),
    .o_mux_cal(mux_cal), .o_mux_level(mux_level));
  // Clock, 5 ns period
  initial
  begin
    forever #2.5 i_clk = ~i_clk;
  end
  ////////////////////////////////////////////////////////////////////////
  // Whole run checked each cycle; a start mid-run must be ignored
  task automatic trace(input bit gnd);
    int k;
    int cal_n;
    begin
      cal_n = 0;
      if (gnd)
        gse = 1;
      else
        fire = 1;
      @(negedge i_clk);
      gse = 0;
      for (k = 0; k <= 30 * SC; k++)
      begin
        fire = (k == 50);
        cal_n += mux_cal;
        `CHK("busy", k < 30 * SC, busy)
        `CHK("mux", k < 30*SC ? 6'h1 << (k/(5*SC)) : 6'h0, mux)
        `CHK("sb", k < 30*SC ? 3'h1 << (k/(10*SC)) : 3'h0, sb)
        `CHK("lvl", 3'(k < 30*SC ? (k/SC) % 5 : 0), level)
        `CHK("done", k > 0 && k % (5*SC) == 0, done)
        `CHK("osc", k < 5 * SC, on_bus)
        if (k == 5 * SC)
          `CHK("defer", 1'b0, mux_cal)
        if (k == 10 * SC)
          `CHK("mlvl", 3'h4, mux_level)
        @(negedge i_clk);
      end
      `CHK("mcal", 5 * FR, cal_n)
    end
  endtask : trace
  // Ground start outside prelaunch does nothing
  task automatic ground_refused();
    begin
      gse = 1;
      @(negedge i_clk);
      gse = 0;
      @(negedge i_clk);
      `CHK("busy", 1'b0, busy)
    end
  endtask : ground_refused
  // Fixed level, stepping, then release back to zero
  task automatic manual_level();
    begin
      pre = 1;
      ctl = 1;
      sel = 3'h3;
      repeat (2) @(negedge i_clk);
      `CHK("fixed", LVL_75, level)
      sel = 3'h5;
      repeat (SC + 1) @(negedge i_clk);
      `CHK("step", LVL_100, level)
      ctl = 0;
      repeat (2) @(negedge i_clk);
      `CHK("rel", LVL_0, level)
    end
  endtask : manual_level
  // Clock enable freezes state; reset mid-run with start held across it
  task automatic freeze_and_reset();
    begin
      ce = 0;
      fire = 1;
      repeat (2) @(negedge i_clk);
      `CHK("frz_idle", 1'b0, busy)
      ce = 1;
      @(negedge i_clk);
      `CHK("frz_go", 6'h01, mux)
      repeat (SC + 2) @(negedge i_clk);
      ce = 0;
      repeat (3 * SC) @(negedge i_clk);
      `CHK("frz_lvl", LVL_25, level)
      i_reset = 1;
      @(negedge i_clk);
      `CHK("rst_mux", 6'h00, mux)
      `CHK("rst_lvl", LVL_0, level)
      i_reset = 0;
      ce = 1;
      @(negedge i_clk);
      `CHK("rst_go", 1'b1, busy)
      fire = 0;
      i_reset = 1;
      @(negedge i_clk);
      i_reset = 0;
      @(negedge i_clk);
      `CHK("rst_idle", 1'b0, busy)
    end
  endtask : freeze_and_reset
  task automatic end_of_test();
    begin
      $display("compared %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0)
        $display("TEST PASSED");
      else
        $display("TEST FAILED");
      $finish;
    end
  endtask : end_of_test
  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    repeat (5) @(negedge i_clk);
    i_reset = 0;
    ground_refused();
    freeze_and_reset();
    trace(0);
    manual_level();
    trace(1);
    end_of_test();
  end
  // Watchdog, well past the expected run of about 300 cycles
  initial
  begin
    #20000;
    bad_count++;
    end_of_test();
  end
endmodule : tb_telemetry_calibration_sequencer
`default_nettype wire

// File: dv/tcs_partner.sv
// Flight computer start, oscillator assembly and multiplexer models
`timescale 1ns/1ps
`default_nettype none
module tcs_partner #(
  parameter int FRAME = 3
) (
  // Clock and command from the bench
  input wire logic i_clk,
  input wire logic i_fire,
  // Calibrate enables from the sequencer
  input wire logic i_en,
  input wire logic i_mux_en,
  // Start line, oscillator input path, multiplexer routine
  output logic o_start,
  output logic o_on_bus,
  output logic o_mux_cal,
  output logic [2:0] o_mux_level
);
  int fcnt = 0;
  int step = 0;
  logic armed = 1'b0;
  logic en_q = 1'b0;
  logic cal = 1'b0;
  // Start is a plain pulse; no handshake exists
  assign o_start = i_fire;
  // Oscillator listens to the bus only while enabled
  assign o_on_bus = i_en;
  // Multiplexer: master frames run free; a rising enable arms the
  // routine, which waits for the next frame boundary to begin
  always @(posedge i_clk)
  begin
    fcnt <= (fcnt == FRAME - 1) ? 0 : fcnt + 1;
    en_q <= i_mux_en;
    if (i_mux_en && !en_q)
      armed <= 1'b1;
    if (fcnt == FRAME - 1)
    begin
      if (armed)
      begin
        armed <= 1'b0;
        cal <= 1'b1;
        step <= 0;
      end
      else if (cal && step == 4)
        cal <= 1'b0;
      else if (cal)
        step <= step + 1;
    end
  end
  assign o_mux_cal = cal;
  assign o_mux_level = 3'(step);
endmodule : tcs_partner
`default_nettype wire

// File: rtl/tcs_defines.svh
// Constants for the telemetry calibration sequencer
// Behaviour
// R1: One start pulse runs the whole sequence
// R2: Six unit calibrate-enable outputs
// R3: Three sideband telemeter calibrate-enable outputs
// R4: Five ascending levels, wrap to zero
// R5: One five-level pass lasts 700 ms
// R6: Exactly six passes per start
// R7: Each pass end advances unit selector
// R8: Oscillator uses calibration bus during pass
// R9: Deselected oscillator restores normal input
// R10: Multiplexer runs its own five-step routine
// R11: Multiplexer waits for next master frame
// R12: Multiplexer holds each level one frame
// R13: Multiplexer restores data after fifth frame
// R14: Inflight and prelaunch modes; ground start prelaunch
// R15: Level advances every 140 ms
// R16: Ground start ORed with flight start
// R17: Start resets selector, enables advance, clock
// R18: Prelaunch ground picks fixed level or stepping
// R19: After sixth pass all off, idle
// R20: At most one unit enable asserted
`ifndef TCS_DEFINES_SVH
`define TCS_DEFINES_SVH
`define TCS_CLK_KHZ 200000
`define TCS_STEP_MS 140
`define TCS_PASS_MS 700
`define TCS_STEP_CNT_W 25
`define TCS_MUX_N 6
`define TCS_SB_N 3
`define TCS_PASS_LAST 3'h5
`define TCS_LEVEL_COUNT 3'h5
`endif

// File: rtl/tcs_pkg.sv
// Types for the telemetry calibration sequencer
package tcs_pkg;
  typedef enum logic [2:0] {
    LVL_0 = 3'b000,
    LVL_25 = 3'b001,
    LVL_50 = 3'b010,
    LVL_75 = 3'b011,
    LVL_100 = 3'b100
  } level_t;
  typedef enum logic {
    ST_IDLE = 1'b0,
    ST_RUN = 1'b1
  } seq_state_t;
endpackage : tcs_pkg

// File: rtl/telemetry_calibration_sequencer.sv
// Calibration level stepper and unit output selector
`timescale 1ns/1ps
`default_nettype none
`include "tcs_defines.svh"
module telemetry_calibration_sequencer #(
  parameter int unsigned STEP_CYCLES = `TCS_STEP_MS * `TCS_CLK_KHZ
) (
  // Clock, reset, enable
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_ce,
  // Start commands and mode
  input wire logic i_start_flight_computer,
  input wire logic i_start_ground_support_equipment,
  input wire logic i_prelaunch,
  // Ground manual level control
  input wire logic i_ground_level_ctl,
  input wire logic [2:0] i_ground_level_sel,
  // Calibration outputs
  output var tcs_pkg::level_t o_level,
  output logic [`TCS_MUX_N-1:0] o_mux_en,
  output logic [`TCS_SB_N-1:0] o_sideband_en,
  output logic o_busy,
  output logic o_pass_done
);
  import tcs_pkg::*;

  localparam logic [`TCS_STEP_CNT_W-1:0] STEP_LAST =
    `TCS_STEP_CNT_W'(STEP_CYCLES - 1);

  // Sideband telemeter served by a given pass; each covers two passes
  function automatic logic [1:0] sideband_of(input logic [2:0] pass);
    sideband_of = pass[2:1];
  endfunction : sideband_of

  ////////////////////////////////////////////////////////////////////////
  seq_state_t state;
  seq_state_t next_state;
  level_t level;
  level_t next_level;
  logic [2:0] pass_idx;
  logic [2:0] next_pass_idx;
  logic [`TCS_STEP_CNT_W-1:0] step_cnt;
  logic [`TCS_STEP_CNT_W-1:0] next_step_cnt;
  logic start_q;

  // Start qualification: ground start only honoured in prelaunch
  wire start_any = i_start_flight_computer |
    (i_start_ground_support_equipment & i_prelaunch); // R14 R16
  wire start_evt = start_any & ~start_q; // R1
  wire busy = (state == ST_RUN);
  wire launch = start_evt & ~busy; // R1

  // Manual level control only while idle in prelaunch
  wire manual = ~busy & i_prelaunch & i_ground_level_ctl; // R18
  wire fixed = manual & (i_ground_level_sel < `TCS_LEVEL_COUNT); // R18
  wire stepping = busy | (manual & ~fixed); // R17 R18
  wire step_tick = stepping & (step_cnt == STEP_LAST); // R15
  wire at_top = (level == LVL_100);
  wire pass_end = busy & step_tick & at_top; // R5 R7
  wire last_pass = (pass_idx == `TCS_PASS_LAST); // R6

  // Level stepper: wraps 100% back to 0%, so a pass is five steps
  wire level_t stepped = at_top ? LVL_0 : level_t'(level + 3'h1); // R4
  always_comb
  begin
    next_level = level;
    if (launch)
      next_level = LVL_0; // R17
    else if (fixed)
      next_level = level_t'(i_ground_level_sel); // R18
    else if (step_tick)
      next_level = stepped; // R4 R15
    else if (!stepping)
      next_level = LVL_0;
  end

  // Step timer restarts whenever stepping is gated off. The period is
  // counted in enabled cycles, so holding the clock enable low stretches
  // the 700 ms pass; the enable must stay high for true timing
  always_comb
  begin
    if (launch || !stepping || step_tick)
      next_step_cnt = '0;
    else
      next_step_cnt = step_cnt + `TCS_STEP_CNT_W'(1); // R15
  end

  // Control flip-flop and pass counter
  always_comb
  begin
    next_state = state;
    next_pass_idx = pass_idx;
    if (launch)
    begin
      next_state = ST_RUN; // R17
      next_pass_idx = 3'h0;
    end
    else if (pass_end)
    begin
      if (last_pass)
      begin
        next_state = ST_IDLE; // R19
        next_pass_idx = 3'h0;
      end
      else
        next_pass_idx = pass_idx + 3'h1; // R7
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Enable decode from the next state, then registered with it, so the
  // relay drivers never see a decode glitch between passes
  wire next_busy = (next_state == ST_RUN);
  wire [`TCS_MUX_N-1:0] next_mux_en;
  wire [`TCS_SB_N-1:0] next_sideband_en;
  genvar g;
  generate
    for (g = 0; g < `TCS_MUX_N; g++)
    begin : g_mux
      // One unit at a time: the pass index picks exactly one bit
      assign next_mux_en[g] = next_busy & (next_pass_idx == 3'(g)); // R2 R20
    end
    for (g = 0; g < `TCS_SB_N; g++)
    begin : g_sb
      // Each sideband telemeter spans two unit passes
      assign next_sideband_en[g] = next_busy &
        (sideband_of(next_pass_idx) == 2'(g)); // R3
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Registers; a low clock enable freezes everything
  always_ff @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      state <= ST_IDLE;
      level <= LVL_0;
      pass_idx <= 3'h0;
      step_cnt <= '0;
      start_q <= 1'b0;
      o_pass_done <= 1'b0;
      o_mux_en <= '0;
      o_sideband_en <= '0;
    end
    else if (i_ce)
    begin
      state <= next_state;
      level <= next_level;
      pass_idx <= next_pass_idx;
      step_cnt <= next_step_cnt;
      start_q <= start_any;
      o_pass_done <= pass_end;
      o_mux_en <= next_mux_en; // R2 R7
      o_sideband_en <= next_sideband_en; // R3
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Level drives the shared calibration bus directly
  assign o_level = level; // R8
  assign o_busy = busy;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_reset);

  a_unit_onehot: assert property ($onehot0(o_mux_en)) // R20
    else $error("more than one unit enable");
  a_sideband_map: assert property (o_busy |->
    o_sideband_en == (3'h1 << sideband_of(pass_idx))) // R3
    else $error("sideband enable does not follow pass");
  a_start_runs: assert property (i_ce && launch |=>
    o_busy && o_mux_en == 6'h01 && o_level == LVL_0) // R1
    else $error("start did not select first unit");
  a_level_order: assert property (o_busy && $past(o_busy) && $past(i_ce)
    && $changed(o_level) |-> o_level == ($past(o_level) == LVL_100 ?
    LVL_0 : level_t'($past(o_level) + 3'h1))) // R4
    else $error("level stepped out of order");
  a_step_timing: assert property (o_busy && $changed(o_level) &&
    $past(o_busy) |-> $past(step_cnt) == STEP_LAST) // R15
    else $error("level changed off the step period");
  a_pass_advance: assert property (i_ce && pass_end && !last_pass |=>
    o_mux_en == ($past(o_mux_en) << 1) && o_pass_done) // R7
    else $error("selector did not advance");
  a_six_passes: assert property (i_ce && pass_end && last_pass |=>
    !o_busy && o_mux_en == 6'h00 && o_sideband_en == 3'h0) // R6
    else $error("sequence did not end after sixth pass");
  a_ground_gate: assert property (i_ce && !o_busy && !i_prelaunch &&
    !i_start_flight_computer |=> !o_busy) // R14
    else $error("ground start accepted inflight");
  a_ground_start: assert property (i_ce && !o_busy && i_prelaunch &&
    i_start_ground_support_equipment && !start_q |=> o_busy) // R16
    else $error("ground start ignored in prelaunch");
  a_fixed_level: assert property (i_ce && fixed |=>
    o_level == level_t'($past(i_ground_level_sel))) // R18
    else $error("fixed ground level not applied");

  // Idle, freeze, sideband one-hot and pulse shape checks
  a_ce_freeze: assert property (!i_ce |=> // R15
    $stable(o_level) && $stable(o_busy) && $stable(o_mux_en))
    else $error("state moved while clock enable low");
  a_idle_quiet: assert property (!o_busy |-> // R19
    o_mux_en == 6'h00 && o_sideband_en == 3'h0)
    else $error("unit enable while idle");
  a_idle_level: assert property (i_ce && !o_busy && !manual |=> // R19
    o_level == LVL_0)
    else $error("level not parked at zero while idle");
  a_sideband_onehot: assert property ($onehot0(o_sideband_en)) // R3
    else $error("more than one sideband enable");
  a_done_pulse: assert property (i_ce && o_pass_done |=> // R5
    !o_pass_done)
    else $error("pass done longer than one cycle");

  c_flight_start: cover property (launch && i_start_flight_computer);
  c_ground_start: cover property (launch && !i_start_flight_computer);
  c_full_run: cover property (pass_end && last_pass);
  c_manual_step: cover property (manual && !fixed && step_tick);
  c_ce_freeze: cover property (o_busy && !i_ce);
endmodule : telemetry_calibration_sequencer
`default_nettype wire
